// file: core/wdtw_pkg.sv
package wdtw_pkg;

  // Bus clock period and the nominal period of the low-power RC oscillator.
  localparam int unsigned PCLK_PERIOD_NS = 20;
  localparam int unsigned LOW_POWER_RC_OSC_PERIOD_NS = 31250;
  // Bus clock cycles per oscillator tick; 50 MHz over 32 kHz, rounded down.
  localparam int unsigned LOW_POWER_RC_OSC_DIV_CYCLES = LOW_POWER_RC_OSC_PERIOD_NS / PCLK_PERIOD_NS;
  localparam int unsigned LOW_POWER_RC_OSC_DIV_W = 11;
  localparam logic [LOW_POWER_RC_OSC_DIV_W-1:0] LOW_POWER_RC_OSC_DIV_LAST = LOW_POWER_RC_OSC_DIV_W'(LOW_POWER_RC_OSC_DIV_CYCLES - 1);

  // Width of the combined prescaler and postscaler count, enough for 128 x 32768 ticks.
  localparam int unsigned CNT_W = 23;
  localparam logic [CNT_W-1:0] PRE_DIV_SHORT = 23'h000020;
  localparam logic [CNT_W-1:0] PRE_DIV_LONG = 23'h000080;
  localparam logic [CNT_W-1:0] CNT_ONE = 23'h000001;

  // Register byte offsets on the APB.
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] RESET_CONTROL_REG_OFFSET = 12'h000;
  localparam logic [ADDR_W-1:0] CFG_OFFSET = 12'h004;
  localparam logic [ADDR_W-1:0] CMD_OFFSET = 12'h008;
  localparam logic [ADDR_W-1:0] STAT_OFFSET = 12'h00C;

  // Field positions of the reset control register.
  localparam int unsigned RESET_CONTROL_REG_IDLE_BIT = 2;
  localparam int unsigned RESET_CONTROL_REG_SLEEP_BIT = 3;
  localparam int unsigned RESET_CONTROL_REG_TIMEOUT_BIT = 4;
  localparam int unsigned RESET_CONTROL_REG_SOFT_EN_BIT = 5;
  localparam logic [31:0] RESET_CONTROL_REG_RESET = 32'h00000000;

  // Field positions of the watchdog configuration word.
  localparam int unsigned CFG_POST_LSB = 0;
  localparam int unsigned CFG_POST_W = 4;
  localparam int unsigned CFG_PRE_BIT = 4;
  localparam int unsigned CFG_WIN_DIS_BIT = 6;
  localparam int unsigned CFG_HARD_EN_BIT = 7;
  localparam logic [31:0] CFG_RESET = 32'h000000DF;
  localparam logic [31:0] CFG_MASK = 32'h000000DF;

  // Command register bits, each a one-shot action when written as one.
  localparam int unsigned CMD_CLEAR_BIT = 0;
  localparam int unsigned CMD_SLEEP_BIT = 1;
  localparam int unsigned CMD_IDLE_BIT = 2;

  // Status register bits.
  localparam int unsigned STAT_RUN_BIT = 0;
  localparam int unsigned STAT_WIN_BIT = 1;
  localparam int unsigned STAT_SLEEP_BIT = 2;
  localparam int unsigned STAT_IDLE_BIT = 3;

  // Power state of the device as seen by the watchdog.
  typedef enum logic [1:0] {WDTW_RUN, WDTW_SLEEP, WDTW_IDLE} wdtw_mode_t;

  // Total timeout in oscillator ticks: prescale ratio shifted by the postscale code.
  function automatic logic [CNT_W-1:0] wdtw_period(input logic pre_sel,
                                                   input logic [3:0] post_sel);
    logic [CNT_W-1:0] pre_div;
    pre_div = pre_sel ? PRE_DIV_LONG : PRE_DIV_SHORT;
    return pre_div << post_sel;
  endfunction : wdtw_period

  // First tick count of the final quarter of the timeout period.
  function automatic logic [CNT_W-1:0] wdtw_window_start(input logic [CNT_W-1:0] period);
    return period - (period >> 2);
  endfunction : wdtw_window_start

endpackage : wdtw_pkg

// file: core/wdtw_low_power_rc_osc_osc.sv
`timescale 1ns/100ps
module wdtw_low_power_rc_osc_osc
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic osc_enable,
  output logic tick
);
  import wdtw_pkg::*;

  // Divider count standing in for the oscillator phase.
  logic [LOW_POWER_RC_OSC_DIV_W-1:0] div_reg;
  logic [LOW_POWER_RC_OSC_DIV_W-1:0] div_next;
  // One-cycle tick pulse, one per nominal 32 kHz period.
  logic tick_reg;
  logic tick_next;

  // The oscillator only runs while enabled, so a stopped watchdog draws no ticks.
  always_comb
  begin
    div_next = div_reg;
    tick_next = 1'b0;
    if (!osc_enable)
    begin
      div_next = '0;
    end
    else if (div_reg == LOW_POWER_RC_OSC_DIV_LAST)
    begin
      div_next = '0;
      tick_next = 1'b1;
    end
    else
    begin
      div_next = div_reg + 11'h001;
    end
  end

  // State register only.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      div_reg <= div_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule : wdtw_low_power_rc_osc_osc

// file: core/wdtw_scaler.sv
`timescale 1ns/100ps
module wdtw_scaler
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic clear,
  input wire logic run,
  input wire logic pre_sel,
  input wire logic [3:0] post_sel,
  output logic timeout,
  output logic window_open
);
  import wdtw_pkg::*;

  // Combined prescaler and postscaler count in oscillator ticks.
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic timeout_reg;
  logic timeout_next;
  logic window_reg;
  logic window_next;
  logic [CNT_W-1:0] period;

  // One counter replaces the two stages; both always clear together, so nothing is lost.
  always_comb
  begin
    period = wdtw_period(pre_sel, post_sel);
    count_next = count_reg;
    timeout_next = 1'b0;
    if (clear || !run)
    begin
      count_next = '0;
    end
    else if (tick)
    begin
      // Greater-or-equal guards against a period shrunk below the count.
      if ((count_reg + CNT_ONE) >= period)
      begin
        count_next = '0;
        timeout_next = 1'b1;
      end
      else
      begin
        count_next = count_reg + CNT_ONE;
      end
    end
    window_next = (count_next >= wdtw_window_start(period));
  end

  // State register only.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_reg <= '0;
      timeout_reg <= 1'b0;
      window_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      timeout_reg <= timeout_next;
      window_reg <= window_next;
    end
  end

  assign timeout = timeout_reg;
  assign window_open = window_reg;

endmodule : wdtw_scaler

// file: core/wdtw_top.sv
// Functional notes
// - Low-power RC oscillator clocks watchdog, enabled together.
// - Prescaler divides 32 kHz by 32 or 128.
// - Prescaler output period nominally 1 or 4 ms.
// - Postscaler gives sixteen ratios, 1:1 to 1:32768.
// - Postscale code n selects ratio two to n.
// - Prescale select one means divide by 128.
// - Reset and clock switch completion clear counters.
// - Sleep or idle entry and exit clear counters.
// - Clear instruction clears counter and scalers.
// - Enabled watchdog keeps counting in sleep, idle.
// - Timeout in sleep or idle wakes, no reset.
// - Timeout flag stays set until software clears.
// - Hard enable keeps watchdog always running.
// - Without hard enable, soft enable bit controls.
// - Device reset clears the soft enable bit.
// - Windowed early clear causes a watchdog reset.
// - Hard enable ignores soft disable, oscillator stays.
`timescale 1ns/100ps
module wdtw_top
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [wdtw_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clk_switch_done,
  input wire logic wake_event,
  output logic wdt_reset_pulse,
  output logic wake_pulse,
  output logic low_power_rc_osc_enable,
  output logic sleep_mode,
  output logic idle_mode
);
  import wdtw_pkg::*;

  // APB answer registers; every transfer takes exactly one access cycle.
  logic pready_reg;
  logic pready_next;
  // The error flag rides with pready, so the master sees both at one edge.
  logic pslverr_reg;
  logic pslverr_next;
  // Read data reload on every setup, zero for a write setup, so they stay put between transfers.
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  // Software-visible control and status state.
  // Reset control word: idle, sleep and timeout flags and the soft enable.
  logic [31:0] reset_control_reg_reg;
  logic [31:0] reset_control_reg_next;
  // Configuration word: postscale code, prescale select, window disable, hard enable.
  logic [31:0] cfg_reg;
  logic [31:0] cfg_next;
  // Power state; only run mode acts on software commands.
  wdtw_mode_t mode_reg;
  wdtw_mode_t mode_next;

  // Registered event outputs.
  // Watchdog reset request, one cycle wide.
  logic reset_pulse_reg;
  logic reset_pulse_next;
  // Wake request out of sleep or idle, one cycle wide.
  logic wake_pulse_reg;
  logic wake_pulse_next;
  // Oscillator enable, one cycle behind the run decision.
  logic low_power_rc_osc_en_reg;
  logic low_power_rc_osc_en_next;
  // Power-state outputs, registered beside the mode itself.
  logic sleep_reg;
  logic sleep_next;
  logic idle_reg;
  logic idle_next;

  // Decoded bus events, valid in the setup cycle or in the completing access cycle.
  // Phase of the transfer as the slave sees it.
  logic setup_phase;
  logic access_done;
  // True for the four implemented word addresses.
  logic addr_mapped;
  // Register writes that land at the completing edge.
  logic wr_reset_control_reg;
  logic wr_cfg;
  // One-shot command strobes from the command word.
  logic cmd_clear;
  logic cmd_sleep;
  logic cmd_idle;
  // Read data chosen by the address during the setup cycle.
  logic [31:0] read_mux;

  // Watchdog datapath links.
  // Run decision from the two enables.
  logic running;
  // Restart request for the combined prescaler and postscaler.
  logic scaler_clear;
  // One-cycle pulse per oscillator period.
  logic osc_tick;
  // One-cycle pulse when the full period has elapsed.
  logic scaler_timeout;
  // High while the count is inside the last quarter of the period.
  logic window_open;
  // Configuration bits decoded once for the whole block.
  logic hard_enable;
  logic window_mode;

  // True when an address hits one of the four words.
  function automatic logic wdtw_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] offset);
    return addr == offset;
  endfunction : wdtw_hit

  // Configuration fields used all over the block.
  assign hard_enable = cfg_reg[CFG_HARD_EN_BIT];
  assign window_mode = !cfg_reg[CFG_WIN_DIS_BIT];

  // The watchdog runs when either the fuse-like bit or the soft bit asks for it.
  assign running = hard_enable || reset_control_reg_reg[RESET_CONTROL_REG_SOFT_EN_BIT];

  // The oscillator follows the enable; it also ticks on through sleep and idle.
  wdtw_low_power_rc_osc_osc u_osc
  (
    .pclk(pclk),
    .presetn(presetn),
    .osc_enable(running),
    .tick(osc_tick)
  );

  // Prescaler and postscaler, cleared by every event listed in the control logic.
  wdtw_scaler u_scaler
  (
    .pclk(pclk),
    .presetn(presetn),
    .tick(osc_tick),
    .clear(scaler_clear),
    .run(running),
    .pre_sel(cfg_reg[CFG_PRE_BIT]),
    .post_sel(cfg_reg[CFG_POST_LSB +: CFG_POST_W]),
    .timeout(scaler_timeout),
    .window_open(window_open)
  );

  // Bus decode. A write lands only at the edge that samples pready high.
  always_comb
  begin
    setup_phase = psel && !penable;
    access_done = psel && penable && pready_reg;
    addr_mapped = wdtw_hit(paddr, RESET_CONTROL_REG_OFFSET) || wdtw_hit(paddr, CFG_OFFSET) ||
                  wdtw_hit(paddr, CMD_OFFSET) || wdtw_hit(paddr, STAT_OFFSET);
    wr_reset_control_reg = access_done && pwrite && wdtw_hit(paddr, RESET_CONTROL_REG_OFFSET);
    wr_cfg = access_done && pwrite && wdtw_hit(paddr, CFG_OFFSET);
    // Each command bit acts only on a write that completes at this edge.
    cmd_clear = access_done && pwrite && wdtw_hit(paddr, CMD_OFFSET) &&
                pwdata[CMD_CLEAR_BIT];
    cmd_sleep = access_done && pwrite && wdtw_hit(paddr, CMD_OFFSET) &&
                pwdata[CMD_SLEEP_BIT];
    cmd_idle = access_done && pwrite && wdtw_hit(paddr, CMD_OFFSET) &&
               pwdata[CMD_IDLE_BIT] && !pwdata[CMD_SLEEP_BIT];
  end

  // Read multiplexer. The command word is write-only and reads as zero.
  always_comb
  begin
    read_mux = 32'h00000000;
    if (wdtw_hit(paddr, RESET_CONTROL_REG_OFFSET))
    begin
      read_mux = reset_control_reg_reg;
    end
    else if (wdtw_hit(paddr, CFG_OFFSET))
    begin
      read_mux = cfg_reg;
    end
    else if (wdtw_hit(paddr, STAT_OFFSET))
    begin
      // Status bits are live views of the watchdog and ignore writes.
      read_mux[STAT_RUN_BIT] = running;
      read_mux[STAT_WIN_BIT] = window_open;
      read_mux[STAT_SLEEP_BIT] = (mode_reg == WDTW_SLEEP);
      read_mux[STAT_IDLE_BIT] = (mode_reg == WDTW_IDLE);
    end
  end

  // APB answer: pready rises for the access cycle, data and error are set up with it.
  always_comb
  begin
    pready_next = setup_phase;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    if (setup_phase)
    begin
      // Unmapped addresses answer with an error and read zero.
      pslverr_next = !addr_mapped;
      prdata_next = pwrite ? 32'h00000000 : read_mux;
    end
  end

  // Bus answer registers only.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end
    else
    begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  // Watchdog control: power state, flags, clears and the reset and wake pulses.
  always_comb
  begin
    reset_control_reg_next = reset_control_reg_reg;
    cfg_next = cfg_reg;
    mode_next = mode_reg;
    reset_pulse_next = 1'b0;
    wake_pulse_next = 1'b0;
    scaler_clear = 1'b0;
    low_power_rc_osc_en_next = running;

    // Software writes go first so that hardware events below win over them.
    if (wr_reset_control_reg)
    begin
      reset_control_reg_next[RESET_CONTROL_REG_IDLE_BIT] = pwdata[RESET_CONTROL_REG_IDLE_BIT];
      reset_control_reg_next[RESET_CONTROL_REG_SLEEP_BIT] = pwdata[RESET_CONTROL_REG_SLEEP_BIT];
      reset_control_reg_next[RESET_CONTROL_REG_TIMEOUT_BIT] = pwdata[RESET_CONTROL_REG_TIMEOUT_BIT];
      // The soft bit always stores; while hard enable is set it simply has no effect.
      reset_control_reg_next[RESET_CONTROL_REG_SOFT_EN_BIT] = pwdata[RESET_CONTROL_REG_SOFT_EN_BIT];
    end
    if (wr_cfg)
    begin
      cfg_next = pwdata & CFG_MASK;
    end

    // A completed clock switch, software or fail-safe, restarts the count.
    if (clk_switch_done)
    begin
      scaler_clear = 1'b1;
    end

    unique case (mode_reg)
      WDTW_RUN:
      begin
        if (scaler_timeout)
        begin
          // Timeout while executing resets the device; the flag survives the reset.
          reset_pulse_next = 1'b1;
          reset_control_reg_next[RESET_CONTROL_REG_TIMEOUT_BIT] = 1'b1;
          reset_control_reg_next[RESET_CONTROL_REG_SOFT_EN_BIT] = 1'b0;
          scaler_clear = 1'b1;
        end
        else if (cmd_clear && running && window_mode && !window_open)
        begin
          // An early clear in window mode is treated as a runaway program.
          // A stopped watchdog has no window, so its clears are simply ignored.
          reset_pulse_next = 1'b1;
          reset_control_reg_next[RESET_CONTROL_REG_TIMEOUT_BIT] = 1'b1;
          reset_control_reg_next[RESET_CONTROL_REG_SOFT_EN_BIT] = 1'b0;
          scaler_clear = 1'b1;
        end
        else if (cmd_sleep)
        begin
          // Entering sleep restarts the count; the flag waits for software.
          mode_next = WDTW_SLEEP;
          reset_control_reg_next[RESET_CONTROL_REG_SLEEP_BIT] = 1'b1;
          scaler_clear = 1'b1;
        end
        else if (cmd_idle)
        begin
          // Idle entry matches sleep entry; sleep wins when both bits are written.
          mode_next = WDTW_IDLE;
          reset_control_reg_next[RESET_CONTROL_REG_IDLE_BIT] = 1'b1;
          scaler_clear = 1'b1;
        end
        else if (cmd_clear)
        begin
          // A clear inside the window, or with the window off, restarts the count.
          scaler_clear = 1'b1;
        end
      end
      WDTW_SLEEP, WDTW_IDLE:
      begin
        // The counter keeps running here; clear commands cannot arrive from a halted CPU.
        if (scaler_timeout)
        begin
          // Wake without reset so execution resumes after the power-save instruction.
          mode_next = WDTW_RUN;
          wake_pulse_next = 1'b1;
          reset_control_reg_next[RESET_CONTROL_REG_TIMEOUT_BIT] = 1'b1;
          scaler_clear = 1'b1;
        end
        else if (wake_event)
        begin
          // Any other wake source also restarts the count on exit.
          mode_next = WDTW_RUN;
          scaler_clear = 1'b1;
        end
      end
    endcase
    // Power-state outputs get their own flops so the pins never see decode glitches.
    sleep_next = (mode_next == WDTW_SLEEP);
    idle_next = (mode_next == WDTW_IDLE);
  end

  // Control registers only; reset clears the soft enable and the power state.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reset_control_reg_reg <= RESET_CONTROL_REG_RESET;
      cfg_reg <= CFG_RESET;
      mode_reg <= WDTW_RUN;
      // Pulses come out of reset low, so no false request follows it.
      reset_pulse_reg <= 1'b0;
      wake_pulse_reg <= 1'b0;
      low_power_rc_osc_en_reg <= 1'b0;
      sleep_reg <= 1'b0;
      idle_reg <= 1'b0;
    end
    else
    begin
      reset_control_reg_reg <= reset_control_reg_next;
      cfg_reg <= cfg_next;
      mode_reg <= mode_next;
      reset_pulse_reg <= reset_pulse_next;
      wake_pulse_reg <= wake_pulse_next;
      low_power_rc_osc_en_reg <= low_power_rc_osc_en_next;
      sleep_reg <= sleep_next;
      idle_reg <= idle_next;
    end
  end

  // Outputs come straight from flip-flops.
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign wdt_reset_pulse = reset_pulse_reg;
  assign wake_pulse = wake_pulse_reg;
  assign low_power_rc_osc_enable = low_power_rc_osc_en_reg;
  assign sleep_mode = sleep_reg;
  assign idle_mode = idle_reg;

endmodule : wdtw_top

// file: dv/wdtw_top_asserts.sv
`timescale 1ns/100ps
// Checker beside the watchdog top; it sees only the top's ports.
module wdtw_top_asserts
  import wdtw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [wdtw_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic clk_switch_done,
  input wire logic wake_event,
  input wire logic wdt_reset_pulse,
  input wire logic wake_pulse,
  input wire logic low_power_rc_osc_enable,
  input wire logic sleep_mode,
  input wire logic idle_mode
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // An access cycle that completes at this edge.
  wire logic acc = psel && penable && pready;
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("access phase did not get ready");
  a_err_unmapped: assert property (psel && !penable && (paddr > 12'h00C || paddr[1:0] != 2'h0)
    |=> pslverr) else $error("unmapped access without error");
  a_cmd_reads_zero: assert property (acc && !pwrite && paddr == CMD_OFFSET |-> prdata == 32'h0)
    else $error("command register read not zero");
  a_reset_single: assert property (wdt_reset_pulse |=> !wdt_reset_pulse)
    else $error("reset pulse longer than one cycle");
  a_wake_single: assert property (wake_pulse |=> !wake_pulse)
    else $error("wake pulse longer than one cycle");
  a_wake_no_reset: assert property (wake_pulse |-> !wdt_reset_pulse ##1 !wdt_reset_pulse)
    else $error("wake came with a reset");
  a_wake_leaves: assert property (wake_pulse |-> ##[0:2] (!sleep_mode && !idle_mode))
    else $error("wake did not return to run");
  a_hard_osc: assert property (acc && pwrite && paddr == CFG_OFFSET && pwdata[CFG_HARD_EN_BIT]
    |-> ##[1:3] low_power_rc_osc_enable) else $error("hard enable left oscillator off");
  a_soft_osc: assert property (acc && pwrite && paddr == RESET_CONTROL_REG_OFFSET && pwdata[RESET_CONTROL_REG_SOFT_EN_BIT]
    |-> ##[1:3] low_power_rc_osc_enable) else $error("soft enable left oscillator off");
  a_exit_run: assert property (wake_event && (sleep_mode || idle_mode)
    |-> ##[1:2] (!sleep_mode && !idle_mode)) else $error("wake event did not leave power save");
  a_sleep_enter: assert property (acc && pwrite && paddr == CMD_OFFSET && pwdata[CMD_SLEEP_BIT]
    && !sleep_mode && !idle_mode |-> ##[1:2] sleep_mode) else $error("sleep not entered");
endmodule : wdtw_top_asserts

bind wdtw_top wdtw_top_asserts u_asserts (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
  .pwdata, .prdata, .pready, .pslverr, .clk_switch_done, .wake_event, .wdt_reset_pulse,
  .wake_pulse, .low_power_rc_osc_enable, .sleep_mode, .idle_mode);

// file: dv/test_watchdog_timer_with_window.sv
`timescale 1ns/100ps
// Self-checking bench: register table first, then the timed watchdog cases.
module test_watchdog_timer_with_window;
  import wdtw_pkg::*;
  typedef struct packed {logic wr; logic [ADDR_W-1:0] a; logic [31:0] d; logic [31:0] x;
    logic e;} wdtw_row_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, wdt_reset_pulse, wake_pulse, low_power_rc_osc_enable, sleep_mode, idle_mode;
  logic clk_switch_done = 1'b0, wake_event = 1'b0;
  logic [31:0] rst_cnt = '0, wake_cnt = '0, rd, c, w;
  logic er;
  int err_total = 0, checked = 0, n, cyc = 0, t, e;
  // Bus clock cycles per oscillator tick.
  localparam int TK = LOW_POWER_RC_OSC_DIV_CYCLES;
  // Register rows: write flag, address, data, expected read data, expected error.
  wdtw_row_t rows [12] = '{
    '{1'b0, RESET_CONTROL_REG_OFFSET, 32'h0, 32'h0, 1'b0}, '{1'b0, CFG_OFFSET, 32'h0, 32'hDF, 1'b0},
    '{1'b0, 12'h010, 32'h0, 32'h0, 1'b1}, '{1'b1, 12'h010, 32'h5, 32'h0, 1'b1},
    '{1'b1, CFG_OFFSET, 32'hFF, 32'h0, 1'b0}, '{1'b0, CFG_OFFSET, 32'h0, 32'hDF, 1'b0},
    '{1'b1, CFG_OFFSET, 32'h0, 32'h0, 1'b0}, '{1'b0, CMD_OFFSET, 32'h0, 32'h0, 1'b0},
    '{1'b1, RESET_CONTROL_REG_OFFSET, 32'h20, 32'h0, 1'b0}, '{1'b0, STAT_OFFSET, 32'h0, 32'h1, 1'b0},
    '{1'b1, RESET_CONTROL_REG_OFFSET, 32'h0, 32'h0, 1'b0}, '{1'b0, STAT_OFFSET, 32'h0, 32'h0, 1'b0}};

  wdtw_top dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .clk_switch_done, .wake_event, .wdt_reset_pulse, .wake_pulse, .low_power_rc_osc_enable,
    .sleep_mode, .idle_mode);

  // The 50 MHz bus clock.
  always #10 pclk = ~pclk;

  // Pulses are counted so a missed or extra one shows as a count mismatch.
  always @(posedge pclk)
  begin
    if (wdt_reset_pulse === 1'b1) rst_cnt <= rst_cnt + 32'h1;
    if (wake_pulse === 1'b1) wake_cnt <= wake_cnt + 32'h1;
    cyc <= cyc + 1;
  end

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x)
    begin
      $display("mismatch %s expected %h seen %h", nm, x, g);
      err_total++;
    end
  endtask : chk

  // One when a measured cycle count lies inside the span that the rules allow.
  function automatic logic [31:0] in_span(input int v, input int lo, input int hi);
    return {31'h0, v >= lo && v <= hi};
  endfunction : in_span

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
    if (n >= 16) err_total++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run

  // Sleep timeout plus window wait take about 93k cycles; this bound cuts a hang.
  initial
  begin
    #1960000;
    err_total++;
    complete_run();
  end

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("osc after reset", 32'h1, {31'h0, low_power_rc_osc_enable});
    foreach (rows[i])
    begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk("row read", rows[i].x, rd);
      chk("row error", {31'h0, rows[i].e}, {31'h0, er});
    end
    repeat (2) @(posedge pclk);
    chk("osc off", 32'h0, {31'h0, low_power_rc_osc_enable});
    // Early clear in window mode forces a reset and sets the flag.
    apb(1'b1, RESET_CONTROL_REG_OFFSET, 32'h20);
    c = rst_cnt;
    apb(1'b1, CMD_OFFSET, 32'h1);
    repeat (4) @(posedge pclk);
    chk("early clear reset", c + 32'h1, rst_cnt);
    apb(1'b0, RESET_CONTROL_REG_OFFSET, 32'h0);
    chk("flag after reset", 32'h10, rd);
    apb(1'b1, RESET_CONTROL_REG_OFFSET, 32'h0);
    apb(1'b0, RESET_CONTROL_REG_OFFSET, 32'h0);
    chk("flag cleared", 32'h0, rd);
    // Hard enable with window disabled; soft disable must not stop it.
    apb(1'b1, CFG_OFFSET, 32'hC0);
    apb(1'b1, RESET_CONTROL_REG_OFFSET, 32'h0);
    apb(1'b0, STAT_OFFSET, 32'h0);
    chk("hard run", 32'h1, rd);
    c = rst_cnt;
    apb(1'b1, CMD_OFFSET, 32'h1);
    repeat (4) @(posedge pclk);
    chk("plain clear", c, rst_cnt);
    // Idle entry sets its flag; a wake event leaves idle but the flag stays.
    apb(1'b1, CMD_OFFSET, 32'h4);
    apb(1'b0, STAT_OFFSET, 32'h0);
    chk("idle state", 32'h9, rd);
    wake_event <= 1'b1;
    @(posedge pclk);
    wake_event <= 1'b0;
    repeat (2) @(posedge pclk);
    apb(1'b0, RESET_CONTROL_REG_OFFSET, 32'h0);
    chk("idle flag kept", 32'h4, rd);
    apb(1'b1, RESET_CONTROL_REG_OFFSET, 32'h0);
    // Sleep timeout, timed from a clock switch that restarts the count.
    apb(1'b1, CMD_OFFSET, 32'h2);
    c = rst_cnt;
    w = wake_cnt;
    repeat (5000) @(posedge pclk);
    clk_switch_done <= 1'b1;
    @(posedge pclk);
    clk_switch_done <= 1'b0;
    n = 0;
    while (wake_cnt == w && n < 60000) begin @(posedge pclk); n++; end
    chk("wake delay", 32'h1, in_span(n, 31 * TK, 32 * TK + 8));
    chk("no reset in sleep", c, rst_cnt);
    apb(1'b0, RESET_CONTROL_REG_OFFSET, 32'h0);
    chk("sleep wake flags", 32'h18, rd);
    apb(1'b0, STAT_OFFSET, 32'h0);
    chk("awake", 32'h1, rd);
    // Window mode under hard enable: restart at a clock switch, wait for the last
    // quarter by polling the window status bit, then clear inside it.
    apb(1'b1, CFG_OFFSET, 32'h80);
    clk_switch_done <= 1'b1;
    @(posedge pclk);
    clk_switch_done <= 1'b0;
    t = cyc;
    rd = '0;
    while (rd[STAT_WIN_BIT] !== 1'b1 && cyc - t < 40000)
    begin
      apb(1'b0, STAT_OFFSET, 32'h0);
    end
    e = cyc - t;
    chk("window opens", 32'h1, in_span(e, 23 * TK, 24 * TK + 12));
    chk("window status", 32'h3, rd);
    c = rst_cnt;
    apb(1'b1, CMD_OFFSET, 32'h1);
    repeat (4) @(posedge pclk);
    chk("window clear", c, rst_cnt);
    apb(1'b0, STAT_OFFSET, 32'h0);
    chk("count restarted", 32'h1, rd);
    // A device reset in mid-run drops the soft enable and restores the configuration.
    apb(1'b1, RESET_CONTROL_REG_OFFSET, 32'h20);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, RESET_CONTROL_REG_OFFSET, 32'h0);
    chk("soft enable after reset", 32'h0, rd);
    apb(1'b0, CFG_OFFSET, 32'h0);
    chk("config after reset", 32'hDF, rd);
    complete_run();
  end
endmodule : test_watchdog_timer_with_window
